// ---- design/calsu_core.sv ----
// Purpose: execution datapath for arithmetic, logic and shift operations
// Assumes: one request per cycle, answer registered one cycle later
// Notes:   register reads and writes of the general file stay outside

module calsu_core (
	input  wire logic                 clk_sys,
	input  wire logic                 rst,
	input  wire calsu_pkg::calsu_req_t req,
	output      calsu_pkg::calsu_rsp_t rsp
);
	import calsu_pkg::*;

	// operand picked from a register image, zero extended
	function automatic logic [31:0] pick(input logic [31:0] r, input calsu_size_t s,
		input logic hi);
		case (s)
			SZ_BYTE: pick = hi ? {24'h0, r[15:8]} : {24'h0, r[7:0]};
			SZ_WORD: pick = hi ? {16'h0, r[31:16]} : {16'h0, r[15:0]};
			default: pick = r;
		endcase
	endfunction

	// result merged back into its register image
	function automatic logic [31:0] place(input logic [31:0] r, input logic [31:0] v,
		input calsu_size_t s, input logic hi);
		case (s)
			SZ_BYTE: place = hi ? {r[31:16], v[7:0], r[7:0]} : {r[31:8], v[7:0]};
			SZ_WORD: place = hi ? {v[15:0], r[15:0]} : {r[31:16], v[15:0]};
			default: place = v;
		endcase
	endfunction

	// sign bit position for the width
	function automatic logic [31:0] topBit(input calsu_size_t s);
		case (s)
			SZ_BYTE: topBit = 32'h00000080;
			SZ_WORD: topBit = 32'h00008000;
			default: topBit = 32'h80000000;
		endcase
	endfunction

	function automatic logic msb(input logic [31:0] v, input calsu_size_t s);
		msb = |(v & topBit(s));
	endfunction

	function automatic logic isZero(input logic [31:0] v, input calsu_size_t s);
		isZero = (pick(v, s, 1'b0) == 32'h0);
	endfunction

	// carry out of the top bit of a 33-bit sum
	function automatic logic carryOut(input logic [32:0] v, input calsu_size_t s);
		case (s)
			SZ_BYTE: carryOut = v[8];
			SZ_WORD: carryOut = v[16];
			default: carryOut = v[32];
		endcase
	endfunction

	// carry into the top nibble, from a xor of operands and sum
	function automatic logic halfCarry(input logic [31:0] x, input calsu_size_t s);
		case (s)
			SZ_BYTE: halfCarry = x[4];
			SZ_WORD: halfCarry = x[12];
			default: halfCarry = x[28];
		endcase
	endfunction

	// one step of shift or rotate; returns carry then value
	function automatic logic [32:0] shiftStep(input logic [31:0] v, input calsu_size_t s,
		input calsu_op_t op, input logic cin);
		logic [31:0] nv;
		logic        fill;
		nv   = 32'h0;
		fill = 1'b0;
		if (op == OP_ASL || op == OP_LSL || op == OP_ROL || op == OP_RCL) begin
			fill = (op == OP_ROL) ? msb(v, s) : ((op == OP_RCL) ? cin : 1'b0);
			nv   = pick({v[30:0], fill}, s, 1'b0);
			shiftStep = {msb(v, s), nv};
		end else begin
			// right moves insert at the sign position of the width
			case (op)
				OP_ASR:  fill = msb(v, s);
				OP_ROR:  fill = v[0];
				OP_RCR:  fill = cin;
				default: fill = 1'b0;
			endcase
			nv = (v >> 1) | (fill ? topBit(s) : 32'h0);
			shiftStep = {v[0], nv};
		end
	endfunction

	calsu_rsp_t          next_rsp;   // answer for the next cycle
	logic [ACC_WIDTH-1:0] macc;      // multiply-accumulate register
	logic [ACC_WIDTH-1:0] next_macc;

	// datapath: all single-cycle operations
	always_comb begin
		calsu_size_t  sz;
		logic [31:0]  a, b, res, dw;
		logic [32:0]  sum, st;
		logic         cin, sub, arith;
		logic [7:0]   bcd;
		logic [15:0]  q16;
		next_rsp       = RSP_RESET;
		next_rsp.flags = req.flags;
		sz    = req.size;
		if (req.op == OP_ADDC || req.op == OP_SUBB || req.op == OP_DADA ||
			req.op == OP_DADS || req.op == OP_TSET)
			sz = SZ_BYTE;
		if (req.op == OP_ADJA || req.op == OP_ADJS)
			sz = SZ_LONG;
		a     = pick(req.dstReg, sz, req.dstHigh);
		b     = req.useImm ? pick(req.imm, sz, 1'b0) : pick(req.srcReg, sz, req.srcHigh);
		dw    = pick(req.dstReg, SZ_WORD, req.dstHigh);
		res   = a;
		cin   = 1'b0;
		sub   = 1'b0;
		arith = 1'b0;
		bcd   = 8'h0;
		q16   = 16'h0;
		st    = 33'h0;
		next_rsp.valid = req.valid;
		case (req.op)
			OP_ADD, OP_SUB: begin
				sub   = (req.op == OP_SUB);
				arith = 1'b1;
			end
			OP_ADDC, OP_SUBB: begin
				sub   = (req.op == OP_SUBB);
				cin   = req.flags.c;
				arith = 1'b1;
			end
			OP_COMP: begin
				sub   = 1'b1;
				arith = 1'b1;
			end
			OP_NEGT: begin
				b     = a;
				a     = 32'h0;
				sub   = 1'b1;
				arith = 1'b1;
			end
			// step of one for bytes, of the request count above byte size
			OP_INCR, OP_DECR: begin
				b     = (sz == SZ_BYTE) ? 32'h1 : {29'h0, req.count};
				sub   = (req.op == OP_DECR);
				arith = 1'b1;
			end
			// adjust by 1, 2 or 4, flags untouched
			OP_ADJA, OP_ADJS: begin
				b     = {29'h0, req.count};
				sub   = (req.op == OP_ADJS);
				arith = 1'b1;
			end
			default: arith = 1'b0;
		endcase
		sum = sub ? ({1'b0, a} - {1'b0, b} - {32'h0, cin})
			: ({1'b0, a} + {1'b0, b} + {32'h0, cin});
		if (arith) begin
			res = pick(sum[31:0], sz, 1'b0);
			next_rsp.result  = place(req.dstReg, res, sz, req.dstHigh);
			next_rsp.wrReg   = (req.op != OP_COMP);
			next_rsp.wrFlags = (req.op != OP_ADJA && req.op != OP_ADJS);
			next_rsp.flags.n = msb(res, sz);
			next_rsp.flags.z = isZero(res, sz);
			next_rsp.flags.v = (sub ? (msb(a, sz) != msb(b, sz)) : (msb(a, sz) == msb(b, sz)))
				&& (msb(res, sz) != msb(a, sz));
			if (req.op != OP_INCR && req.op != OP_DECR) begin
				next_rsp.flags.c = carryOut(sum, sz);
				next_rsp.flags.h = halfCarry(a ^ b ^ sum[31:0], sz);
			end
			// zero is only kept across a carry chain, never newly set
			if (req.op == OP_ADDC || req.op == OP_SUBB)
				next_rsp.flags.z = req.flags.z & isZero(res, sz);
		end
		case (req.op)
			// decimal adjust of a byte result
			OP_DADA, OP_DADS: begin
				bcd = a[7:0];
				if (req.op == OP_DADA) begin
					if (req.flags.h || bcd[3:0] > BCD_LO_LIM)
						bcd = bcd + BCD_LO_ADJ;
					if (req.flags.c || a[7:0] > BCD_HI_LIM) begin
						bcd = bcd + BCD_HI_ADJ;
						next_rsp.flags.c = 1'b1;
					end
				end else begin
					if (req.flags.h)
						bcd = bcd - BCD_LO_ADJ;
					if (req.flags.c)
						bcd = bcd - BCD_HI_ADJ;
				end
				next_rsp.result  = place(req.dstReg, {24'h0, bcd}, SZ_BYTE, req.dstHigh);
				next_rsp.flags.n = bcd[7];
				next_rsp.flags.z = (bcd == 8'h0);
				next_rsp.wrReg   = 1'b1;
				next_rsp.wrFlags = 1'b1;
			end
			// unsigned multiply, destination twice the source width
			OP_UMUL: begin
				next_rsp.wrReg = 1'b1;
				// operands widened first, a bare 8x8 product would keep only 8 bits
				if (sz == SZ_BYTE)
					next_rsp.result = place(req.dstReg,
						{16'h0, {8'h0, dw[7:0]} * {8'h0, b[7:0]}}, SZ_WORD, req.dstHigh);
				else
					next_rsp.result = req.dstReg[15:0] * b[15:0];
			end
			OP_SMUL: begin
				next_rsp.wrReg   = 1'b1;
				next_rsp.wrFlags = 1'b1;
				if (sz == SZ_BYTE) begin
					// sign extended to the product width, low bits are the signed product
					res = {16'h0, {{8{dw[7]}}, dw[7:0]} * {{8{b[7]}}, b[7:0]}};
					next_rsp.result  = place(req.dstReg, res, SZ_WORD, req.dstHigh);
					next_rsp.flags.n = res[15];
					next_rsp.flags.z = (res[15:0] == 16'h0);
				end else begin
					res = {{16{req.dstReg[15]}}, req.dstReg[15:0]} * {{16{b[15]}}, b[15:0]};
					next_rsp.result  = res;
					next_rsp.flags.n = res[31];
					next_rsp.flags.z = (res == 32'h0);
				end
			end
			OP_UDIV, OP_SDIV: begin
				next_rsp.wrFlags = 1'b1;
				next_rsp.flags.z = isZero(b, sz);
				// a zero divisor leaves the destination untouched
				next_rsp.wrReg   = !isZero(b, sz);
				if (isZero(b, sz)) begin
					next_rsp.result = req.dstReg;
				end else if (sz == SZ_BYTE) begin
					if (req.op == OP_UDIV)
						res = {16'h0, 8'(dw[15:0] % b[7:0]), 8'(dw[15:0] / b[7:0])};
					else
						res = {16'h0, 8'($signed(dw[15:0]) % $signed(b[7:0])),
							8'($signed(dw[15:0]) / $signed(b[7:0]))};
					next_rsp.result  = place(req.dstReg, res, SZ_WORD, req.dstHigh);
					next_rsp.flags.n = res[7];
				end else begin
					if (req.op == OP_UDIV) begin
						q16 = 16'(req.dstReg / b[15:0]);
						res = {16'(req.dstReg % b[15:0]), q16};
					end else begin
						q16 = 16'($signed(req.dstReg) / $signed(b[15:0]));
						res = {16'($signed(req.dstReg) % $signed(b[15:0])), q16};
					end
					next_rsp.result  = res;
					next_rsp.flags.n = q16[15];
				end
			end
			// zero or sign extension of the low part
			OP_ZEXT, OP_SEXT: begin
				if (sz == SZ_WORD) begin
					res = {24'h0, dw[7:0]};
					if (req.op == OP_SEXT && dw[7])
						res = 32'h0000ff00 | res;
					next_rsp.result = place(req.dstReg, res, SZ_WORD, req.dstHigh);
				end else begin
					res = {16'h0, req.dstReg[15:0]};
					if (req.op == OP_SEXT && req.dstReg[15])
						res = 32'hffff0000 | res;
					next_rsp.result = res;
				end
				next_rsp.wrReg   = 1'b1;
				next_rsp.wrFlags = 1'b1;
				next_rsp.flags.n = msb(res, sz);
				next_rsp.flags.z = isZero(res, sz);
				next_rsp.flags.v = 1'b0;
			end
			// flags from memory byte, bit seven set
			OP_TSET: begin
				next_rsp.result  = {24'h0, req.dstReg[7:0] | TSET_BIT};
				next_rsp.wrMem   = 1'b1;
				next_rsp.wrFlags = 1'b1;
				next_rsp.flags.n = req.dstReg[7];
				next_rsp.flags.z = (req.dstReg[7:0] == 8'h0);
				next_rsp.flags.v = 1'b0;
			end
			OP_AST: begin
				next_rsp.result = macc[31:0];
				next_rsp.wrReg  = 1'b1;
			end
			// bitwise logic with register or immediate
			OP_AND, OP_OR, OP_XOR, OP_INV: begin
				case (req.op)
					OP_AND:  res = a & b;
					OP_OR:   res = a | b;
					OP_XOR:  res = a ^ b;
					default: res = pick(~a, sz, 1'b0);
				endcase
				next_rsp.result  = place(req.dstReg, res, sz, req.dstHigh);
				next_rsp.wrReg   = 1'b1;
				next_rsp.wrFlags = 1'b1;
				next_rsp.flags.n = msb(res, sz);
				next_rsp.flags.z = isZero(res, sz);
				next_rsp.flags.v = 1'b0;
			end
			// one or two steps of shift or rotate
			OP_ASL, OP_ASR, OP_LSL, OP_LSR, OP_ROL, OP_ROR, OP_RCL, OP_RCR: begin
				st = shiftStep(a, sz, req.op, req.flags.c);
				next_rsp.flags.v = (req.op == OP_ASL) && (msb(st[31:0], sz) != msb(a, sz));
				if (req.count == 3'h2) begin
					st = shiftStep(st[31:0], sz, req.op, st[32]);
					if (req.op == OP_ASL && msb(st[31:0], sz) != msb(a, sz))
						next_rsp.flags.v = 1'b1;
				end
				next_rsp.result  = place(req.dstReg, st[31:0], sz, req.dstHigh);
				next_rsp.wrReg   = 1'b1;
				next_rsp.wrFlags = 1'b1;
				next_rsp.flags.n = msb(st[31:0], sz);
				next_rsp.flags.z = isZero(st[31:0], sz);
				next_rsp.flags.c = st[32];
			end
			default: ;
		endcase
		// an idle cycle must not write anything
		if (!req.valid) begin
			next_rsp.wrReg   = 1'b0;
			next_rsp.wrMem   = 1'b0;
			next_rsp.wrFlags = 1'b0;
		end
	end

	// accumulator: clear, load and multiply-accumulate
	always_comb begin
		logic signed [31:0] prod;
		logic signed [42:0] acc;
		prod      = $signed(req.srcReg[15:0]) * $signed(req.dstReg[15:0]);
		acc       = 43'sh0;
		next_macc = macc;
		if (req.valid) begin
			case (req.op)
				OP_ACLR: next_macc = '0;
				OP_ALD:  next_macc = {{(ACC_WIDTH-32){req.srcReg[31]}}, req.srcReg};
				// signed product added to the accumulator
				OP_MACC: begin
					if (req.macSat) begin
						// saturation works on the low 32 bits only
						acc = 43'($signed(macc[31:0])) + 43'(prod);
						if (acc > 43'($signed(SAT_MAX)))
							next_macc = {{(ACC_WIDTH-32){1'b0}}, SAT_MAX};
						else if (acc < 43'($signed(SAT_MIN)))
							next_macc = {{(ACC_WIDTH-32){1'b1}}, SAT_MIN};
						else
							next_macc = ACC_WIDTH'(acc);
					end else begin
						next_macc = macc + ACC_WIDTH'(prod);
					end
				end
				default: next_macc = macc;
			endcase
		end
	end

	// registers: synchronous reset, answer lands one cycle after request
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rsp  <= RSP_RESET;
			macc <= '0;
		end else begin
			rsp  <= next_rsp;
			macc <= next_macc;
		end
	end

endmodule

// ---- design/calsu_pkg.sv ----
// Purpose: shared types and constants of the arithmetic, logic and shift unit
// Assumes: decoder hands over register images already read from the file
// Notes:   operand size and operation codes are decoded upstream

package calsu_pkg;

	// operand sizes
	typedef enum logic [1:0] {
		SZ_BYTE = 2'h0,
		SZ_WORD = 2'h1,
		SZ_LONG = 2'h2
	} calsu_size_t;

	// operations carried out by the unit
	typedef enum logic [5:0] {
		OP_NONE  = 6'h00, OP_ADD  = 6'h01, OP_SUB  = 6'h02, OP_ADDC = 6'h03,
		OP_SUBB  = 6'h04, OP_INCR = 6'h05, OP_DECR = 6'h06, OP_ADJA = 6'h07,
		OP_ADJS  = 6'h08, OP_DADA = 6'h09, OP_DADS = 6'h0a, OP_UMUL = 6'h0b,
		OP_SMUL  = 6'h0c, OP_UDIV = 6'h0d, OP_SDIV = 6'h0e, OP_COMP = 6'h0f,
		OP_NEGT  = 6'h10, OP_ZEXT = 6'h11, OP_SEXT = 6'h12, OP_TSET = 6'h13,
		OP_MACC  = 6'h14, OP_ACLR = 6'h15, OP_ALD  = 6'h16, OP_AST  = 6'h17,
		OP_AND   = 6'h18, OP_OR   = 6'h19, OP_XOR  = 6'h1a, OP_INV  = 6'h1b,
		OP_ASL   = 6'h1c, OP_ASR  = 6'h1d, OP_LSL  = 6'h1e, OP_LSR  = 6'h1f,
		OP_ROL   = 6'h20, OP_ROR  = 6'h21, OP_RCL  = 6'h22, OP_RCR  = 6'h23
	} calsu_op_t;

	// condition flags
	typedef struct packed {
		logic h;
		logic n;
		logic z;
		logic v;
		logic c;
	} calsu_flags_t;

	// one request from the sequencer
	typedef struct packed {
		logic         valid;
		calsu_op_t    op;
		calsu_size_t  size;
		logic [2:0]   count;   // step: 1, 2 or 4
		logic         dstHigh; // upper byte or upper half of destination
		logic         srcHigh; // upper byte or upper half of source
		logic         useImm;  // source is immediate data
		logic         macSat;  // saturating accumulate mode
		logic [31:0]  dstReg;  // destination register image or memory data
		logic [31:0]  srcReg;  // source register image or memory data
		logic [31:0]  imm;     // immediate data
		calsu_flags_t flags;   // current condition flags
	} calsu_req_t;

	// one answer to the sequencer
	typedef struct packed {
		logic         valid;
		logic         wrReg;   // write result to destination register
		logic         wrMem;   // write result byte back to memory
		logic         wrFlags; // update condition flags
		logic [31:0]  result;  // full destination image after merge
		calsu_flags_t flags;
	} calsu_rsp_t;

	localparam int          ACC_WIDTH   = 42;
	localparam logic [31:0] SAT_MAX     = 32'h7fffffff;
	localparam logic [31:0] SAT_MIN     = 32'h80000000;
	localparam logic [7:0]  TSET_BIT    = 8'h80;
	localparam logic [7:0]  BCD_HI_ADJ  = 8'h60;
	localparam logic [7:0]  BCD_LO_ADJ  = 8'h06;
	localparam logic [7:0]  BCD_HI_LIM  = 8'h99;
	localparam logic [3:0]  BCD_LO_LIM  = 4'h9;
	localparam calsu_rsp_t  RSP_RESET   = '0;

endpackage

// ---- verification/calsu_core_chk.sv ----
// Purpose: port-level checks of the arithmetic, logic and shift unit
// Assumes: every taken request is answered on the next rising edge
// Notes:   bound to calsu_core at the foot of this file
module calsu_core_chk
	import calsu_pkg::*;
(
	input wire logic                  clk_sys,
	input wire logic                  rst,
	input wire calsu_pkg::calsu_req_t req,
	input wire calsu_pkg::calsu_rsp_t rsp
);
	timeunit 1ns;
	timeprecision 1ps;

	// one domain, so clock and reset are given once
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	property p_answer; req.valid |=> rsp.valid; endproperty
	a_answer: assert property (p_answer)
		else $error("request not answered on the next edge");
	// idle cycles must not leave stale strobes behind
	property p_idle; !req.valid |=> !(rsp.valid || rsp.wrReg || rsp.wrMem || rsp.wrFlags); endproperty
	a_idle: assert property (p_idle)
		else $error("answer or strobe without request");
	// reset itself must clear the answer, so no disable here
	property p_reset; disable iff (1'b0) rst |=> rsp == RSP_RESET; endproperty
	a_reset: assert property (p_reset)
		else $error("answer not cleared by reset");
	property p_compare; req.valid && req.op == OP_COMP |=> !rsp.wrReg && rsp.wrFlags; endproperty
	a_compare: assert property (p_compare)
		else $error("compare wrote the register or skipped flags");
	property p_negate;
		req.valid && req.op == OP_NEGT && req.size == SZ_LONG
			|=> rsp.result == 32'h0 - $past(req.dstReg);
	endproperty
	a_negate: assert property (p_negate)
		else $error("negate result wrong");
	property p_invert;
		req.valid && req.op == OP_INV && req.size == SZ_LONG |=> rsp.result == ~$past(req.dstReg);
	endproperty
	a_invert: assert property (p_invert)
		else $error("invert result wrong");
	property p_adjust;
		req.valid && req.op == OP_ADJA |=> !rsp.wrFlags
			&& rsp.result == $past(req.dstReg) + {29'h0, $past(req.count)};
	endproperty
	a_adjust: assert property (p_adjust)
		else $error("address adjust result wrong");
	property p_zext;
		req.valid && req.op == OP_ZEXT && req.size == SZ_LONG
			|=> rsp.result == {16'h0, $past(req.dstReg[15:0])};
	endproperty
	a_zext: assert property (p_zext)
		else $error("zero extension wrong");
	property p_tset; req.valid && req.op == OP_TSET |=> rsp.wrMem && !rsp.wrReg && rsp.result[7]; endproperty
	a_tset: assert property (p_tset)
		else $error("test and set did not write back bit 7");
	// a store right after a load must already see the loaded value
	property p_ldst;
		req.valid && req.op == OP_ALD ##1 req.valid && req.op == OP_AST |=> rsp.result == $past(req.srcReg, 2);
	endproperty
	a_ldst: assert property (p_ldst)
		else $error("store after load returned a stale value");

	c_tset: cover property (req.valid && req.op == OP_TSET);
	c_macSat: cover property (req.valid && req.op == OP_MACC && req.macSat);
	c_ldst: cover property (req.valid && req.op == OP_ALD ##1 req.valid && req.op == OP_AST);
endmodule

bind calsu_core calsu_core_chk i_chk (.clk_sys(clk_sys), .rst(rst), .req(req), .rsp(rsp));

// ---- verification/calsu_seq_model.sv ----
// Purpose: behavioural sequencer that feeds requests to the unit
// Assumes: a request is taken at the rising edge after it is driven
// Notes:   released data lines carry the inverse of the last value
module calsu_seq_model
	import calsu_pkg::*;
(
	input wire logic                  clk_sys,
	output     calsu_pkg::calsu_req_t req
);
	timeunit 1ns;
	timeprecision 1ps;

	initial req = '0;

	// drive one request; release after its edge unless another follows
	task automatic send(input calsu_req_t r, input logic rel);
		calsu_req_t q;
		q = r;
		if (q.op == OP_SUB && q.useImm && q.size == SZ_BYTE) begin
			q.op = OP_ADD;
			q.imm = 32'h0 - q.imm;
		end
		@(posedge clk_sys);
		req <= q;
		if (rel) begin
			@(posedge clk_sys);
			q.valid = 1'b0;
			q.dstReg = ~q.dstReg;
			q.srcReg = ~q.srcReg;
			q.imm = ~q.imm;
			req <= q;
		end
	endtask
endmodule

// ---- verification/calsu_core_bench.sv ----
// Purpose: self-checking bench for the arithmetic, logic and shift unit
// Assumes: the sequencer model drives requests, the bench judges answers
// Notes:   flags are packed h,n,z,v,c; masks pick the ones judged
module calsu_core_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import calsu_pkg::*;

	localparam logic [31:0] ALL = 32'hffffffff;
	logic       clk_sys = 1'b0; // 50 MHz
	logic       rst     = 1'b1; // held 16 cycles
	calsu_req_t req;            // from the sequencer model
	calsu_rsp_t rsp;            // answer of the unit
	int         errCount    = 0;
	int         comparisons = 0;

	always #10 clk_sys = ~clk_sys;

	calsu_seq_model i_seq (.clk_sys(clk_sys), .req(req));
	calsu_core      i_dut (.clk_sys(clk_sys), .rst(rst), .req(req), .rsp(rsp));

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errCount++;
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic calsu_req_t mk(calsu_op_t op, calsu_size_t sz, logic [31:0] d, logic [31:0] s);
		mk = '0;
		mk.valid = 1'b1;
		mk.op = op;
		mk.size = sz;
		mk.count = 3'h1;
		mk.dstReg = d;
		mk.srcReg = s;
	endfunction

	// one request, answer judged one edge later under result and flag masks
	task automatic run(input calsu_req_t r, input logic [31:0] res, input logic [31:0] rm,
			input logic [4:0] f, input logic [4:0] fm);
		i_seq.send(r, 1'b1);
		#1;
		check({31'h0, rsp.valid}, 32'h1);
		check(rsp.result & rm, res & rm);
		check({27'h0, rsp.flags & fm}, {27'h0, f & fm});
	endtask

	task automatic t_arith();
		calsu_req_t r;
		r = mk(OP_ADD, SZ_BYTE, 32'h123456ff, 32'h1);
		run(r, 32'h12345600, ALL, 5'h15, 5'h1f);
		r = mk(OP_SUB, SZ_WORD, 32'h00050000, 32'h6);
		r.dstHigh = 1'b1;
		run(r, 32'hffff0000, ALL, 5'h09, 5'h0f);
		r = mk(OP_ADD, SZ_LONG, 32'h7fffffff, 32'h0);
		r.useImm = 1'b1;
		r.imm = 32'h1;
		run(r, 32'h80000000, ALL, 5'h0a, 5'h0f);
		// byte subtract of immediate goes out as an add of the negated value
		r = mk(OP_SUB, SZ_BYTE, 32'h00000010, 32'h0);
		r.useImm = 1'b1;
		r.imm = 32'h3;
		run(r, 32'h0000000d, ALL, 5'h0, 5'h0);
		r = mk(OP_ADDC, SZ_BYTE, 32'hab0000f0, 32'h20);
		r.flags.c = 1'b1;
		run(r, 32'hab000011, ALL, 5'h01, 5'h01);
		r.op = OP_SUBB;
		r.srcReg = 32'h5;
		run(r, 32'hab0000ea, ALL, 5'h00, 5'h01);
		r = mk(OP_INCR, SZ_BYTE, 32'h000000ff, 32'h0);
		r.count = 3'h2;
		run(r, 32'h0, ALL, 5'h04, 5'h04);
		r = mk(OP_DECR, SZ_WORD, 32'h55550001, 32'h0);
		r.count = 3'h2;
		run(r, 32'h5555ffff, ALL, 5'h08, 5'h0c);
		r = mk(OP_ADJA, SZ_LONG, 32'hfffffffe, 32'h0);
		r.count = 3'h4;
		run(r, 32'h2, ALL, 5'h0, 5'h0);
		r.op = OP_ADJS;
		r.count = 3'h2;
		run(r, 32'hfffffffc, ALL, 5'h0, 5'h0);
		r = mk(OP_DADA, SZ_BYTE, 32'h41, 32'h0);
		r.flags.h = 1'b1;
		run(r, 32'h47, ALL, 5'h00, 5'h01);
		r.op = OP_DADS;
		r.dstReg = 32'h1f;
		run(r, 32'h19, ALL, 5'h00, 5'h01);
		r = mk(OP_DADA, SZ_BYTE, 32'h9a, 32'h0);
		run(r, 32'h0, ALL, 5'h05, 5'h05);
	endtask

	task automatic t_muldiv();
		calsu_req_t r;
		r = mk(OP_UMUL, SZ_BYTE, 32'habcd00ff, 32'hff);
		run(r, 32'habcdfe01, ALL, 5'h0, 5'h0);
		r.op = OP_SMUL;
		run(r, 32'habcd0001, ALL, 5'h0, 5'h0c);
		r = mk(OP_SMUL, SZ_WORD, 32'h1234fffe, 32'h3);
		run(r, 32'hfffffffa, ALL, 5'h08, 5'h0c);
		r = mk(OP_UDIV, SZ_BYTE, 32'h107, 32'h10);
		run(r, 32'h0710, ALL, 5'h0, 5'h04);
		r = mk(OP_SDIV, SZ_WORD, 32'hfffffff9, 32'h2);
		run(r, 32'hfffffffd, ALL, 5'h08, 5'h0c);
		r.srcReg = 32'h0;
		run(r, 32'h0, 32'h0, 5'h04, 5'h04);
		check({31'h0, rsp.wrReg}, 32'h0);
	endtask

	task automatic t_misc();
		calsu_req_t r;
		r = mk(OP_COMP, SZ_LONG, 32'h89abcdef, 32'h89abcdef);
		run(r, 32'h0, 32'h0, 5'h04, 5'h0f);
		check({30'h0, rsp.wrReg, rsp.wrFlags}, 32'h1);
		r = mk(OP_NEGT, SZ_LONG, 32'h1, 32'h0);
		run(r, ALL, ALL, 5'h09, 5'h0d);
		r = mk(OP_ZEXT, SZ_LONG, 32'hffff8085, 32'h0);
		run(r, 32'h00008085, ALL, 5'h0, 5'h0e);
		r = mk(OP_SEXT, SZ_WORD, 32'habcd1285, 32'h0);
		run(r, 32'habcdff85, ALL, 5'h08, 5'h0e);
		r = mk(OP_TSET, SZ_BYTE, 32'h0, 32'h0);
		run(r, 32'h80, 32'hff, 5'h04, 5'h0e);
		check({30'h0, rsp.wrMem, rsp.wrReg}, 32'h2);
		r = mk(OP_INV, SZ_BYTE, 32'h5a00, 32'h0);
		r.dstHigh = 1'b1;
		run(r, 32'ha500, ALL, 5'h0, 5'h0);
		r = mk(OP_INV, SZ_LONG, 32'h0f0f0f0f, 32'h0);
		run(r, 32'hf0f0f0f0, ALL, 5'h08, 5'h0e);
	endtask

	// accumulator: clear, load, plain and saturating multiply-accumulate and store
	task automatic t_mac();
		calsu_req_t r;
		i_seq.send(mk(OP_ALD, SZ_LONG, 32'h13579bdf, 32'h13579bdf), 1'b0);
		run(mk(OP_AST, SZ_LONG, 32'h0, 32'h0), 32'h13579bdf, ALL, 5'h0, 5'h0);
		i_seq.send(mk(OP_ACLR, SZ_LONG, 32'h0, 32'h0), 1'b0);
		run(mk(OP_AST, SZ_LONG, 32'h0, 32'h0), 32'h0, ALL, 5'h0, 5'h0);
		for (int s = 0; s < 2; s++) begin
			i_seq.send(mk(OP_ALD, SZ_LONG, 32'h7fffffff, 32'h7fffffff), 1'b0);
			r = mk(OP_MACC, SZ_LONG, 32'h2, 32'h3);
			r.macSat = s[0];
			i_seq.send(r, 1'b0);
			r = mk(OP_AST, SZ_LONG, 32'h0, 32'h0);
			run(r, s ? SAT_MAX : 32'h80000005, ALL, 5'h0, 5'h0);
		end
	endtask

	task automatic t_logic();
		calsu_req_t  r;
		calsu_op_t   lop[3]  = '{OP_AND, OP_OR, OP_XOR};
		logic [31:0] lres[3] = '{32'haaaaf000, 32'haaaafff0, 32'haaaa0ff0};
		calsu_op_t   sop[8]  = '{OP_ASL, OP_ASR, OP_LSL, OP_LSR, OP_ROL, OP_ROR, OP_RCL, OP_RCR};
		logic [7:0]  sres[8] = '{8'h02, 8'hc0, 8'h04, 8'h20, 8'h03, 8'h60, 8'h07, 8'he0};
		logic [7:0]  two     = 8'b11101100; // step of two, entry 0 at bit 0
		logic [7:0]  cy      = 8'b00010011; // carry out, entry 0 at bit 0
		for (int i = 0; i < 3; i++) begin
			r = mk(lop[i], SZ_WORD, 32'haaaaf0f0, 32'h0);
			r.useImm = 1'b1;
			r.imm = 32'h0000ff00;
			run(r, lres[i], ALL, 5'h0, 5'h02);
		end
		for (int i = 0; i < 8; i++) begin
			r = mk(sop[i], SZ_BYTE, 32'h5a5a5a81, 32'h0);
			r.count = two[i] ? 3'h2 : 3'h1;
			r.flags.c = 1'b1;
			run(r, {24'h5a5a5a, sres[i]}, ALL, {4'h0, cy[i]}, 5'h01);
		end
	endtask

	task automatic conclude();
		$display("errors %0d comparisons %0d", errCount, comparisons);
		if (errCount == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// watchdog: the whole run needs well under 10 us
	initial begin
		#200000;
		errCount++;
		conclude();
	end

	initial begin
		repeat (15) @(posedge clk_sys);
		#1;
		check({rsp.valid, rsp.wrReg, rsp.wrMem, rsp.wrFlags, rsp.result[27:0]}, 32'h0);
		@(posedge clk_sys) rst <= 1'b0;
		t_arith();
		t_muldiv();
		t_misc();
		t_mac();
		t_logic();
		repeat (2) @(posedge clk_sys);
		#1;
		check({31'h0, rsp.valid}, 32'h0);
		conclude();
	end
endmodule
